// file: rtl/flash_poll_pkg.sv
package flash_poll_pkg;
  // Bus widths of the flash side.
  localparam int ADDR_W = 22;
  localparam int DATA_W = 16;
  // Data bus bit positions of the status bits.
  localparam int POLL_BIT_POS    = 7;
  localparam int TOGGLE1_POS     = 6;
  localparam int TIMEOUT_POS     = 5;
  localparam int TOGGLE2_POS     = 2;
  // Clock rate and flash read cycle timing.
  localparam int CLK_PERIOD_NS   = 10;
  localparam int READ_TIME_NS    = 70;
  localparam int READ_CYCLES     = (READ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RECOVER_TIME_NS = 30;
  localparam int RECOVER_CYCLES  = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W           = 4;
  // Result codes reported to the user.
  localparam logic [1:0] RES_PASS = 2'h0;
  localparam logic [1:0] RES_FAIL = 2'h1;
  // Reset values of the pin drivers.
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 22'h00_0000;
  // Flash reset command word, written on failure.
  localparam logic [DATA_W-1:0] RESET_CMD = 16'h00F0;

  typedef enum logic [8:0] {
    ST_IDLE    = 9'b0_0000_0001,
    ST_RD_LOW  = 9'b0_0000_0010,
    ST_RD_HOLD = 9'b0_0000_0100,
    ST_RD_GAP  = 9'b0_0000_1000,
    ST_EVAL    = 9'b0_0001_0000,
    ST_WR_LOW  = 9'b0_0010_0000,
    ST_WR_GAP  = 9'b0_0100_0000,
    ST_FINAL   = 9'b0_1000_0000,
    ST_DONE    = 9'b1_0000_0000
  } poll_state_t;

  typedef enum logic [1:0] {
    PH_FIRST  = 2'h0,
    PH_SECOND = 2'h1,
    PH_RECHK  = 2'h2,
    PH_DATA   = 2'h3
  } poll_phase_t;
endpackage

// file: rtl/pin_sync.sv
`timescale 1ns/10ps
// Two flip-flop synchroniser for a bus of pin inputs.
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

// file: rtl/flash_status_poller.sv
`timescale 1ns/10ps
// How it works
// - Host reads status at the programmed address.
// - Host polls inside a selected erase sector.
// - After true data, host reads once more.
// - Timeout seen, host rechecks poll bit.
// - Host double-reads; unchanged toggle means done.
// - Toggling with timeout, recheck then reset.
// - Interrupted toggle polling restarts from scratch.
module flash_status_poller (
  // Clock and reset.
  input  wire logic                              i_clk,
  input  wire logic                              i_arst_n,
  // User command port.
  input  wire logic                              i_start,
  input  wire logic                              i_use_toggle,
  input  wire logic [flash_poll_pkg::ADDR_W-1:0] i_valid_status_address,
  input  wire logic                              i_expected_bit,
  input  wire logic                              i_abort,
  output logic                                   o_busy,
  output logic                                   o_done,
  output logic [1:0]                             o_result,
  output logic [flash_poll_pkg::DATA_W-1:0]      o_final_data,
  output logic                                   o_ready_level,
  // Flash pins.
  output logic [flash_poll_pkg::ADDR_W-1:0]      o_addr,
  output logic                                   o_ce_n,
  output logic                                   o_oe_n,
  output logic                                   o_we_n,
  input  wire logic [flash_poll_pkg::DATA_W-1:0] i_dq,
  output logic [flash_poll_pkg::DATA_W-1:0]      o_dq,
  output logic                                   o_dq_oe,
  input  wire logic                              i_ready_busy_out
);
  import flash_poll_pkg::*;

  logic [DATA_W:0] pin_sync_w;

  // Data and ready/busy pins come from the flash and are resynchronised.
  pin_sync #(.W(DATA_W + 1)) u_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_async  ({i_ready_busy_out, i_dq}),
    .o_sync   (pin_sync_w)
  );

  poll_state_t              state_ff,  nxt_state;
  poll_phase_t              phase_ff,  nxt_phase;
  logic [CNT_W-1:0]         cnt_ff,    nxt_cnt;
  logic [DATA_W-1:0]        prev_ff,   nxt_prev;
  logic [DATA_W-1:0]        cur_ff,    nxt_cur;
  logic                     toggle_ff, nxt_toggle;
  logic                     expect_ff, nxt_expect;
  logic [ADDR_W-1:0]        addr_ff,   nxt_addr;
  logic                     ce_n_ff,   nxt_ce_n;
  logic                     oe_n_ff,   nxt_oe_n;
  logic                     we_n_ff,   nxt_we_n;
  logic                     dq_oe_ff,  nxt_dq_oe;
  logic [DATA_W-1:0]        dq_ff,     nxt_dq;
  logic                     done_ff,   nxt_done;
  logic [1:0]               res_ff,    nxt_res;
  logic [DATA_W-1:0]        fin_ff,    nxt_fin;
  logic                     busy_ff,   nxt_busy;
  logic                     rdy_ff,    nxt_rdy;
  logic [1:0]               warm_ff,   nxt_warm;

  // Toggling if either toggle bit changed between two reads.
  function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b);
    toggled = (a[TOGGLE1_POS] ^ b[TOGGLE1_POS]) | (a[TOGGLE2_POS] ^ b[TOGGLE2_POS]);
  endfunction

  // Poll bit matches the true datum.
  function automatic logic poll_ok(input logic [DATA_W-1:0] d, input logic e);
    poll_ok = (d[POLL_BIT_POS] == e);
  endfunction

  always_comb begin
    nxt_state  = state_ff;
    nxt_phase  = phase_ff;
    nxt_cnt    = cnt_ff;
    nxt_prev   = prev_ff;
    nxt_cur    = cur_ff;
    nxt_toggle = toggle_ff;
    nxt_expect = expect_ff;
    nxt_addr   = addr_ff;
    nxt_ce_n   = ce_n_ff;
    nxt_oe_n   = oe_n_ff;
    nxt_we_n   = we_n_ff;
    nxt_dq_oe  = dq_oe_ff;
    nxt_dq     = dq_ff;
    nxt_done   = 1'b0;
    nxt_res    = res_ff;
    nxt_fin    = fin_ff;
    nxt_busy   = busy_ff;
    // The synchroniser resets low, so ready is held high until it has refilled.
    nxt_warm   = {warm_ff[0], 1'b1};
    nxt_rdy    = warm_ff[1] ? pin_sync_w[DATA_W] : 1'b1;
    case (state_ff)
      ST_IDLE: begin
        if (i_start) begin
          // Status is read at the caller's valid address inside the busy bank.
          nxt_addr   = i_valid_status_address;
          nxt_expect = i_expected_bit;
          nxt_toggle = i_use_toggle;
          nxt_phase  = PH_FIRST;
          nxt_busy   = 1'b1;
          nxt_cnt    = '0;
          nxt_state  = ST_RD_LOW;
        end
      end
      ST_RD_LOW: begin
        nxt_ce_n  = 1'b0;
        nxt_oe_n  = 1'b0;
        nxt_cnt   = '0;
        nxt_state = ST_RD_HOLD;
      end
      ST_RD_HOLD: begin
        // Wait the access time plus the synchroniser delay, then sample.
        if (cnt_ff == CNT_W'(READ_CYCLES + 2)) begin
          nxt_cur   = pin_sync_w[DATA_W-1:0];
          nxt_ce_n  = 1'b1;
          nxt_oe_n  = 1'b1;
          nxt_cnt   = '0;
          nxt_state = ST_RD_GAP;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      ST_RD_GAP: begin
        // Each read is a separate strobe so toggle bits advance per read.
        if (cnt_ff == CNT_W'(RECOVER_CYCLES)) begin
          nxt_state = ST_EVAL;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      ST_EVAL: begin
        nxt_prev  = cur_ff;
        nxt_cnt   = '0;
        nxt_state = ST_RD_LOW;
        if (i_abort) begin
          // Interrupted polling is abandoned; a new start begins afresh.
          nxt_busy  = 1'b0;
          nxt_state = ST_IDLE;
        end else if (phase_ff == PH_DATA) begin
          // One more read after completion gives valid data on all bits.
          nxt_fin   = cur_ff;
          nxt_res   = RES_PASS;
          nxt_state = ST_FINAL;
        end else if (toggle_ff) begin
          if (phase_ff == PH_FIRST) begin
            nxt_phase = PH_SECOND;
          end else if (!toggled(prev_ff, cur_ff)) begin
            nxt_phase = PH_DATA;
          end else if (phase_ff == PH_RECHK) begin
            nxt_res   = RES_FAIL;
            nxt_state = ST_WR_LOW;
          end else if (cur_ff[TIMEOUT_POS]) begin
            nxt_phase = PH_RECHK;
          end
        end else begin
          if (poll_ok(cur_ff, expect_ff)) begin
            nxt_phase = PH_DATA;
          end else if (phase_ff == PH_RECHK) begin
            nxt_res   = RES_FAIL;
            nxt_state = ST_WR_LOW;
          end else if (cur_ff[TIMEOUT_POS]) begin
            nxt_phase = PH_RECHK;
          end
        end
      end
      ST_WR_LOW: begin
        // Failure: write the reset command to leave status mode.
        nxt_ce_n  = 1'b0;
        nxt_we_n  = 1'b0;
        nxt_dq_oe = 1'b1;
        nxt_dq    = RESET_CMD;
        if (cnt_ff == CNT_W'(READ_CYCLES)) begin
          nxt_cnt   = '0;
          nxt_state = ST_WR_GAP;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      ST_WR_GAP: begin
        nxt_we_n = 1'b1;
        nxt_ce_n = 1'b1;
        if (cnt_ff == CNT_W'(RECOVER_CYCLES)) begin
          nxt_dq_oe = 1'b0;
          nxt_state = ST_FINAL;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      ST_FINAL: begin
        nxt_done  = 1'b1;
        nxt_busy  = 1'b0;
        nxt_state = ST_DONE;
      end
      ST_DONE: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_ff  <= ST_IDLE;
      phase_ff  <= PH_FIRST;
      cnt_ff    <= '0;
      prev_ff   <= DATA_RST;
      cur_ff    <= DATA_RST;
      toggle_ff <= 1'b0;
      expect_ff <= 1'b0;
      addr_ff   <= ADDR_RST;
      ce_n_ff   <= 1'b1;
      oe_n_ff   <= 1'b1;
      we_n_ff   <= 1'b1;
      dq_oe_ff  <= 1'b0;
      dq_ff     <= DATA_RST;
      done_ff   <= 1'b0;
      res_ff    <= RES_PASS;
      fin_ff    <= DATA_RST;
      busy_ff   <= 1'b0;
      rdy_ff    <= 1'b1;
      warm_ff   <= 2'h0;
    end else begin
      state_ff  <= nxt_state;
      phase_ff  <= nxt_phase;
      cnt_ff    <= nxt_cnt;
      prev_ff   <= nxt_prev;
      cur_ff    <= nxt_cur;
      toggle_ff <= nxt_toggle;
      expect_ff <= nxt_expect;
      addr_ff   <= nxt_addr;
      ce_n_ff   <= nxt_ce_n;
      oe_n_ff   <= nxt_oe_n;
      we_n_ff   <= nxt_we_n;
      dq_oe_ff  <= nxt_dq_oe;
      dq_ff     <= nxt_dq;
      done_ff   <= nxt_done;
      res_ff    <= nxt_res;
      fin_ff    <= nxt_fin;
      busy_ff   <= nxt_busy;
      rdy_ff    <= nxt_rdy;
      warm_ff   <= nxt_warm;
    end
  end

  assign o_busy        = busy_ff;
  assign o_done        = done_ff;
  assign o_result      = res_ff;
  assign o_final_data  = fin_ff;
  assign o_ready_level = rdy_ff;
  assign o_addr        = addr_ff;
  assign o_ce_n        = ce_n_ff;
  assign o_oe_n        = oe_n_ff;
  assign o_we_n        = we_n_ff;
  assign o_dq          = dq_ff;
  assign o_dq_oe       = dq_oe_ff;
endmodule

// file: sim/poll_checker.sv
`timescale 1ns/10ps
module poll_checker (
  input wire logic                              i_clk,
  input wire logic                              i_arst_n,
  input wire logic                              i_start,
  input wire logic [flash_poll_pkg::ADDR_W-1:0] i_valid_status_address,
  input wire logic                              o_busy,
  input wire logic                              o_done,
  input wire logic [1:0]                        o_result,
  input wire logic [flash_poll_pkg::ADDR_W-1:0] o_addr,
  input wire logic                              o_ce_n,
  input wire logic                              o_oe_n,
  input wire logic                              o_we_n,
  input wire logic [flash_poll_pkg::DATA_W-1:0] o_dq,
  input wire logic                              o_dq_oe
);
  import flash_poll_pkg::*;
  logic [3:0]        nrd_ff;
  logic [3:0]        nxt_nrd;
  logic              oe_n_ff;
  logic              rcmd_ff;
  logic              nxt_rcmd;
  logic [ADDR_W-1:0] va_ff;
  logic [ADDR_W-1:0] nxt_va;
  logic              go;
  logic              pass;
  logic              fail;
  // Counts reads and notes reset writes since the last accepted start.
  always_comb begin
    go = i_start && !o_busy;
    pass = o_done && o_result == RES_PASS;
    fail = o_done && o_result == RES_FAIL;
    nxt_nrd = nrd_ff + ((!o_oe_n && oe_n_ff && nrd_ff != 4'hF) ? 4'h1 : 4'h0);
    if (go) nxt_nrd = 4'h0;
    nxt_rcmd = !go && (rcmd_ff || (!o_we_n && o_dq_oe && o_dq == RESET_CMD));
    nxt_va = go ? i_valid_status_address : va_ff;
  end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      nrd_ff <= 4'h0;
      oe_n_ff <= 1'b1;
      rcmd_ff <= 1'b0;
      va_ff <= ADDR_RST;
    end else begin
      nrd_ff <= nxt_nrd;
      oe_n_ff <= o_oe_n;
      rcmd_ff <= nxt_rcmd;
      va_ff <= nxt_va;
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  a_read_at_va: assert property (!o_oe_n |-> o_addr == va_ff)
    else $error("read away from status address");
  a_pass_two_reads: assert property (pass |-> nrd_ff >= 4'h2)
    else $error("pass too early");
  a_fail_recheck: assert property (fail |-> nrd_ff >= 4'h2)
    else $error("fail without recheck");
  a_fail_sends_reset: assert property (fail |-> rcmd_ff)
    else $error("fail without reset command");
  a_pass_no_reset: assert property (pass |-> !rcmd_ff)
    else $error("reset command on pass");
  a_write_is_reset: assert property (!o_we_n |-> o_dq_oe && o_dq == RESET_CMD && o_oe_n)
    else $error("stray write");
  a_done_pulse: assert property (o_done |-> !o_busy ##1 !o_done)
    else $error("done not a pulse");
  a_reset_then_done: assert property ($rose(o_we_n) && o_dq_oe |-> ##[1:8] o_done)
    else $error("no done after reset command");
  a_strobe_needs_ce: assert property ((!o_oe_n || !o_we_n) |-> !o_ce_n)
    else $error("strobe without chip enable");
  c_pass: cover property (pass);
  c_fail: cover property (fail);
  c_reset_write: cover property (!o_we_n);
endmodule

// file: sim/flash_model.sv
`timescale 1ns/10ps
module flash_model (
  // Flash pins.
  input  wire logic                              i_oe_n,
  input  wire logic                              i_we_n,
  input  wire logic [flash_poll_pkg::DATA_W-1:0] i_dq,
  output logic [flash_poll_pkg::DATA_W-1:0]      o_dq,
  output logic                                   o_rb_oe
);
  import flash_poll_pkg::*;
  int                left = 0;
  logic              erase = 1'b0;
  logic              tmo = 1'b0;
  logic              tgl = 1'b0;
  logic [DATA_W-1:0] datum = DATA_RST;
  logic [DATA_W-1:0] last = DATA_RST;
  wire               busy = left > 0 || tmo;
  // Value presented during a read: status while busy, array data otherwise.
  wire  [DATA_W-1:0] stat = busy ?
    {8'h00, !erase && !datum[7], tgl, tmo, 2'h0, erase && tgl, 2'h0} :
    datum;
  // Starts an operation that stays busy for n reads, or until reset when it fails.
  task automatic begin_op(input int n, input logic er, input logic fl, input logic [15:0] d);
    left = n;
    erase = er;
    tmo = fl;
    datum = d;
  endtask
  always @(posedge i_oe_n) begin
    last = stat;
    if (busy) begin
      tgl = ~tgl;
      left = left > 0 ? left - 1 : 0;
    end
  end
  always @(posedge i_we_n) begin
    if (i_dq == RESET_CMD) begin
      tmo = 1'b0;
      left = 0;
    end
  end
  // A released bus shows the inverse of the last read so stale data never matches.
  always_comb begin
    if (i_oe_n) o_dq = ~last;
    else o_dq = stat;
  end
  assign o_rb_oe = busy;
endmodule

// file: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import flash_poll_pkg::*;
  logic              clk = 1'b0;
  logic              arst_n, start, use_toggle, exp_bit, abort, busy, done, ready_level;
  logic              ce_n, oe_n, we_n, dq_oe, rb_oe;
  logic [1:0]        result;
  logic [ADDR_W-1:0] va, addr;
  logic [DATA_W-1:0] final_data, dq_out, flash_dq;
  wire  [DATA_W-1:0] dq = dq_oe ? dq_out : flash_dq;
  // Pull-up on the shared ready line.
  wire               rb_pin = !rb_oe;
  int                fail_count = 0;
  int                checked = 0;
  flash_status_poller dut_u (
    .i_clk(clk), .i_arst_n(arst_n), .i_start(start), .i_use_toggle(use_toggle),
    .i_valid_status_address(va), .i_expected_bit(exp_bit), .i_abort(abort),
    .o_busy(busy), .o_done(done), .o_result(result), .o_final_data(final_data),
    .o_ready_level(ready_level), .o_addr(addr), .o_ce_n(ce_n), .o_oe_n(oe_n),
    .o_we_n(we_n), .i_dq(dq), .o_dq(dq_out), .o_dq_oe(dq_oe), .i_ready_busy_out(rb_pin));
  flash_model flash_u (.i_oe_n(oe_n), .i_we_n(we_n), .i_dq(dq), .o_dq(flash_dq),
    .o_rb_oe(rb_oe));
  always #5 clk = ~clk;
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic run_op(input int n, input logic er, input logic fl, input logic tg,
                        input logic [15:0] d);
    int i;
    flash_u.begin_op(n, er, fl, d);
    @(negedge clk);
    start = 1'b1;
    use_toggle = tg;
    exp_bit = d[7];
    va = 22'h01_2340 + 22'(n);
    @(negedge clk);
    start = 1'b0;
    repeat (6) @(negedge clk);
    check(16'(ready_level), 16'(!(n > 0 || fl)));
    for (i = 0; i < 3000 && done !== 1'b1; i++) @(negedge clk);
    check(16'(done), 16'h0001);
    check(16'(result), 16'(fl ? RES_FAIL : RES_PASS));
    if (!fl) check(final_data, d);
    repeat (4) @(negedge clk);
    check(16'(ready_level), 16'h0001);
  endtask
  task automatic sc_prog_poll;
    run_op(3, 1'b0, 1'b0, 1'b0, 16'h00A5);
  endtask
  task automatic sc_done_at_once;
    run_op(0, 1'b0, 1'b0, 1'b0, 16'h1234);
  endtask
  task automatic sc_erase_poll;
    run_op(4, 1'b1, 1'b0, 1'b0, 16'hFFFF);
  endtask
  task automatic sc_prog_toggle;
    run_op(3, 1'b0, 1'b0, 1'b1, 16'h5A3C);
  endtask
  task automatic sc_erase_toggle;
    run_op(5, 1'b1, 1'b0, 1'b1, 16'hFFFF);
  endtask
  task automatic sc_poll_timeout;
    run_op(0, 1'b0, 1'b1, 1'b0, 16'h0080);
  endtask
  task automatic sc_toggle_timeout;
    run_op(2, 1'b0, 1'b1, 1'b1, 16'h0042);
  endtask
  // A protected target: a short busy spell, then array data that was never written.
  task automatic sc_protected;
    run_op(1, 1'b0, 1'b0, 1'b1, 16'h0F0F);
    run_op(2, 1'b1, 1'b0, 1'b1, 16'h1234);
  endtask
  task automatic sc_abort_restart;
    int i;
    logic seen;
    seen = 1'b0;
    flash_u.begin_op(50, 1'b0, 1'b0, 16'h0011);
    @(negedge clk);
    start = 1'b1;
    use_toggle = 1'b1;
    exp_bit = 1'b0;
    va = 22'h00_0100;
    @(negedge clk);
    start = 1'b0;
    repeat (40) @(negedge clk);
    abort = 1'b1;
    for (i = 0; i < 40 && busy !== 1'b0; i++) begin
      seen = seen | done;
      @(negedge clk);
    end
    abort = 1'b0;
    check(16'(busy), 16'h0000);
    check(16'(seen | done), 16'h0000);
    check(16'(oe_n), 16'h0001);
    run_op(2, 1'b0, 1'b0, 1'b1, 16'h0011);
  endtask
  task automatic sc_mid_reset;
    int i;
    flash_u.begin_op(50, 1'b1, 1'b0, 16'hFFFF);
    @(negedge clk);
    start = 1'b1;
    use_toggle = 1'b0;
    exp_bit = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (20) @(negedge clk);
    arst_n = 1'b0;
    flash_u.begin_op(0, 1'b0, 1'b0, 16'hFFFF);
    repeat (4) @(negedge clk);
    check(16'({busy, oe_n, we_n, ready_level}), 16'h0007);
    arst_n = 1'b1;
    for (i = 0; i < 2; i++) begin
      @(negedge clk);
      check(16'({busy, oe_n, ready_level}), 16'h0003);
    end
  endtask
  initial begin
    arst_n = 1'b0;
    start = 1'b0;
    use_toggle = 1'b0;
    exp_bit = 1'b0;
    abort = 1'b0;
    va = ADDR_RST;
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    sc_prog_poll;
    sc_done_at_once;
    sc_erase_poll;
    sc_prog_toggle;
    sc_erase_toggle;
    sc_poll_timeout;
    sc_toggle_timeout;
    sc_abort_restart;
    sc_mid_reset;
    sc_protected;
    test_done;
  end
  initial begin
    #400_000;
    fail_count++;
    test_done;
  end
endmodule
bind flash_status_poller poll_checker chk_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_start(i_start), .i_valid_status_address(i_valid_status_address), .o_busy(o_busy),
  .o_done(o_done), .o_result(o_result), .o_addr(o_addr), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
  .o_we_n(o_we_n), .o_dq(o_dq), .o_dq_oe(o_dq_oe));
